// ### hw/uat_params.svh
// constants for the serial channel: offsets, reset values, counts
`ifndef UAT_PARAMS_SVH
`define UAT_PARAMS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define UAT_A_DATA 8'h00
`define UAT_A_IER  8'h04
`define UAT_A_ISR  8'h08
`define UAT_A_LCR  8'h0C
`define UAT_A_MCR  8'h10
`define UAT_A_LSR  8'h14
`define UAT_A_DIV  8'h18
`define UAT_A_EFR  8'h1C
// ----------------------------------------
// reset values
// ----------------------------------------
`define UAT_LCR_RST 8'h03
`define UAT_DIV_RST 16'h0001
// ----------------------------------------
// timing and sizes
// ----------------------------------------
`define UAT_SUB_LAST 4'hF
`define UAT_SUB_MID  4'h7
`define UAT_PRE_LAST 2'h3
`define UAT_DEPTH    8'h80
`define UAT_TMO_BASE 11'h0C0
`define UAT_TRIG0    8'h08
`define UAT_TRIG1    8'h10
`define UAT_TRIG2    8'h38
`define UAT_TRIG3    8'h3C
`endif

// ### hw/uat_pkg.sv
// types of the serial channel: machine states and the state record
package uat_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
		TX_STOP} uat_tx_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
		RX_STOP} uat_rx_t;
	typedef struct packed {
		logic [127:0][7:0]  txm;
		logic [6:0]         txw, txr;
		logic [7:0]         txc;
		logic [127:0][10:0] rxm;
		logic [6:0]         rxw, rxr;
		logic [7:0]         rxc;
		logic [7:0]         interrupt_mask_register, line_format_register, modem_control_register, fifo_setup_register, enhanced_feature_register;
		logic [15:0]        div, bcnt;
		logic [1:0]         pre;
		logic               tick;
		logic               rx1, rx2, rxp, ct1, ct2, ctp;
		uat_tx_t            ts;
		logic [3:0]         tsub;
		logic [2:0]         tn;
		logic [7:0]         tsh;
		logic               tpar, tx;
		uat_rx_t            rs;
		logic [3:0]         rsub;
		logic [2:0]         rn;
		logic [7:0]         rsh;
		logic               rpar;
		logic [10:0]        tmo;
		logic               tmof, ovr, rts_n, rcf, irq;
		logic [31:0]        prdata;
		logic               pready, pslverr;
	} uat_state_t;
endpackage : uat_pkg

// ### hw/uat_top.sv
// serial channel: transmit, receive, auto rts/cts, apb registers
//
// Local design decisions: the register offsets and the APB register port.
`include "uat_params.svh"
`timescale 1ns/100ps
`default_nettype none
module uat_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx,
	input  wire logic        cts_n,
	output logic             tx,
	output logic             rts_n,
	output logic             irq
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] uat_trig(input logic [1:0] sel);
		case (sel)
			2'h0: return `UAT_TRIG0;
			2'h1: return `UAT_TRIG1;
			2'h2: return `UAT_TRIG2;
			default: return `UAT_TRIG3;
		endcase
	endfunction : uat_trig

	function automatic logic [7:0] uat_mask(input logic [1:0] len);
		return 8'hFF >> (2'h3 - len);
	endfunction : uat_mask

	function automatic logic [10:0] uat_lim(input logic [7:0] l);
		logic [3:0] wl;
		wl = 4'h7 + {2'h0, l[1:0]} + {3'h0, l[3]} + {3'h0, l[2]};
		return {1'b0, wl, 6'h0} + `UAT_TMO_BASE;
	endfunction : uat_lim

	uat_pkg::uat_state_t s, n;
	logic       acc, wr, rd, rx_pop, rstop, autorts, pend;
	logic [7:0] cap, up, lo, line_state_register, interrupt_source_register;

	assign acc = psel & penable & s.pready;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign cap = s.fifo_setup_register[0] ? `UAT_DEPTH : 8'h01;
	assign rx_pop = rd && paddr == `UAT_A_DATA && s.rxc != 8'h00;
	assign rstop = s.rs == uat_pkg::RX_STOP && s.tick
		&& s.rsub == `UAT_SUB_LAST;
	assign autorts = s.enhanced_feature_register[6] & s.modem_control_register[1];
	// hysteresis: the trigger levels either side of the selected one; fifo depth above the top level, zero below the bottom
	assign up = s.fifo_setup_register[7:6] == 2'h3 ? `UAT_DEPTH
		: uat_trig(s.fifo_setup_register[7:6] + 2'h1);
	assign lo = s.fifo_setup_register[7:6] == 2'h0 ? 8'h00
		: uat_trig(s.fifo_setup_register[7:6] - 2'h1);
	assign line_state_register = {1'b0,
		s.txc == 8'h00 && s.ts == uat_pkg::TX_IDLE,
		s.txc == 8'h00,
		s.rxc != 8'h00 ? s.rxm[s.rxr][10:8] : 3'h0,
		s.ovr, s.rxc != 8'h00};
	assign pend = (s.interrupt_mask_register[1] & line_state_register[5]) | s.rcf | (s.interrupt_mask_register[0] & s.tmof)
		| (s.interrupt_mask_register[0] & (s.fifo_setup_register[0] ? s.rxc >= uat_trig(s.fifo_setup_register[7:6])
		: s.rxc != 8'h00));
	assign interrupt_source_register = {2'h0, s.rcf, 1'b0, s.interrupt_mask_register[0] & s.tmof,
		s.interrupt_mask_register[0] & (s.fifo_setup_register[0] ? s.rxc >= uat_trig(s.fifo_setup_register[7:6])
		: s.rxc != 8'h00),
		s.interrupt_mask_register[1] & line_state_register[5], ~pend};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic       tpush, tpop, rpush, pe;
		logic [7:0] d, rv;
		logic       hit;
		pe = 1'b0;
		n = s;
		tpush = 1'b0;
		tpop = 1'b0;
		rpush = 1'b0;
		d = 8'h00;
		rv = 8'h00;
		hit = 1'b1;
		n.tick = 1'b0;
		n.pready = psel & ~penable;
		n.rx1 = rx;
		n.rx2 = s.rx1;
		n.rxp = s.rx2;
		n.ct1 = cts_n;
		n.ct2 = s.ct1;
		n.ctp = s.ct2;
		// baud: prescale then divide; divisor zero acts as one
		pe = s.modem_control_register[7] ? s.pre == `UAT_PRE_LAST : 1'b1;
		n.pre = s.pre + 2'h1;
		if (pe) begin
			if (s.div == 16'h0000 || s.bcnt >= s.div - 16'h0001) begin
				n.bcnt = 16'h0000;
				n.tick = 1'b1;
			end else begin
				n.bcnt = s.bcnt + 16'h0001;
			end
		end
		// register read data is captured in the setup cycle
		case (paddr)
			`UAT_A_DATA: rv = s.rxm[s.rxr][7:0];
			`UAT_A_IER:  rv = s.interrupt_mask_register;
			`UAT_A_ISR:  rv = interrupt_source_register;
			`UAT_A_LCR:  rv = s.line_format_register;
			`UAT_A_MCR:  rv = s.modem_control_register;
			`UAT_A_LSR:  rv = line_state_register;
			`UAT_A_DIV:  rv = 8'h00;
			`UAT_A_EFR:  rv = s.enhanced_feature_register;
			default:     hit = 1'b0;
		endcase
		if (psel & ~penable) begin
			n.prdata = paddr == `UAT_A_DIV ? {16'h0000, s.div}
				: {24'h000000, rv};
			n.pslverr = ~hit;
		end
		if (wr) begin
			case (paddr)
				`UAT_A_DATA: tpush = s.txc < cap;
				`UAT_A_IER: begin
					n.interrupt_mask_register[3:0] = pwdata[3:0];
					if (s.enhanced_feature_register[4]) begin
						n.interrupt_mask_register[7:4] = pwdata[7:4];
					end
				end
				`UAT_A_ISR: n.fifo_setup_register = pwdata[7:0] & 8'hF9;
				`UAT_A_LCR: n.line_format_register = pwdata[7:0];
				`UAT_A_MCR: n.modem_control_register = pwdata[7:0];
				`UAT_A_DIV: n.div = pwdata[15:0];
				`UAT_A_EFR: n.enhanced_feature_register = pwdata[7:0];
				default: n.pslverr = s.pslverr;
			endcase
		end
		if (tpush) begin
			n.txm[s.txw] = pwdata[7:0];
			n.txw = s.txw + 7'h01;
		end
		// ----------------------------------------
		// transmitter
		// ----------------------------------------
		if (s.tick) begin
			n.tsub = s.tsub + 4'h1;
		end
		case (s.ts)
			uat_pkg::TX_IDLE: begin
				n.tx = 1'b1;
				n.tsub = 4'h0;
				// cts is only looked at between characters
				if (s.tick && s.txc != 8'h00
						&& !(s.enhanced_feature_register[7] && s.ct2)) begin
					d = s.txm[s.txr] & uat_mask(s.line_format_register[1:0]);
					tpop = 1'b1;
					n.tsh = d;
					n.tpar = s.line_format_register[4] ? ^d : ~^d;
					n.tn = 3'h0;
					n.tx = 1'b0;
					n.ts = uat_pkg::TX_START;
				end
			end
			uat_pkg::TX_START: if (s.tick && s.tsub == `UAT_SUB_LAST) begin
				n.tx = s.tsh[0];
				n.ts = uat_pkg::TX_DATA;
			end
			uat_pkg::TX_DATA: if (s.tick && s.tsub == `UAT_SUB_LAST) begin
				if (s.tn == {1'b0, s.line_format_register[1:0]} + 3'h4) begin
					n.tn = 3'h0;
					n.tx = s.line_format_register[3] ? s.tpar : 1'b1;
					n.ts = s.line_format_register[3] ? uat_pkg::TX_PAR : uat_pkg::TX_STOP;
				end else begin
					n.tsh = s.tsh >> 1;
					n.tx = s.tsh[1];
					n.tn = s.tn + 3'h1;
				end
			end
			uat_pkg::TX_PAR: if (s.tick && s.tsub == `UAT_SUB_LAST) begin
				n.tx = 1'b1;
				n.ts = uat_pkg::TX_STOP;
			end
			uat_pkg::TX_STOP: if (s.tick && s.tsub == `UAT_SUB_LAST) begin
				if (s.line_format_register[2] && s.tn == 3'h0) begin
					n.tn = 3'h1;
				end else begin
					n.ts = uat_pkg::TX_IDLE;
				end
			end
			default: n.ts = uat_pkg::TX_IDLE;
		endcase
		if (tpop) begin
			n.txr = s.txr + 7'h01;
		end
		n.txc = s.txc + {7'h00, tpush} - {7'h00, tpop};
		// ----------------------------------------
		// receiver
		// ----------------------------------------
		if (s.tick) begin
			n.rsub = s.rsub + 4'h1;
		end
		case (s.rs)
			uat_pkg::RX_IDLE: begin
				n.rsub = 4'h0;
				if (s.rxp && !s.rx2) begin
					n.rs = uat_pkg::RX_START;
				end
			end
			uat_pkg::RX_START: if (s.tick && s.rsub == `UAT_SUB_MID) begin
				n.rsub = 4'h0;
				n.rn = 3'h0;
				// a glitch shorter than half a bit is not a start
				n.rs = s.rx2 ? uat_pkg::RX_IDLE
					: uat_pkg::RX_DATA;
			end
			uat_pkg::RX_DATA: if (s.tick && s.rsub == `UAT_SUB_LAST) begin
				n.rsh = {s.rx2, s.rsh[7:1]};
				n.rn = s.rn + 3'h1;
				if (s.rn == {1'b0, s.line_format_register[1:0]} + 3'h4) begin
					n.rs = s.line_format_register[3] ? uat_pkg::RX_PAR : uat_pkg::RX_STOP;
				end
			end
			uat_pkg::RX_PAR: if (s.tick && s.rsub == `UAT_SUB_LAST) begin
				n.rpar = s.rx2;
				n.rs = uat_pkg::RX_STOP;
			end
			uat_pkg::RX_STOP: if (rstop) begin
				n.rs = uat_pkg::RX_IDLE;
				rpush = s.rxc < cap || rx_pop;
				n.ovr = s.ovr | ~rpush;
			end
			default: n.rs = uat_pkg::RX_IDLE;
		endcase
		if (rpush) begin
			d = s.rsh >> (2'h3 - s.line_format_register[1:0]);
			n.rxm[s.rxw] = {d == 8'h00 && !s.rx2, !s.rx2,
				s.line_format_register[3] && (s.rpar != (s.line_format_register[4] ? ^d : ~^d)), d};
			n.rxw = s.rxw + 7'h01;
		end
		if (rx_pop) begin
			n.rxr = s.rxr + 7'h01;
		end
		n.rxc = s.rxc + {7'h00, rpush} - {7'h00, rx_pop};
		// a new overrun in the cycle of the clearing read still sets
		if (rd && paddr == `UAT_A_LSR) begin
			n.ovr = n.ovr & ~(s.ovr & s.prdata[1] & ~(rstop & ~rpush));
		end
		// receive timeout counts ticks while data waits unread
		if (s.rxc == 8'h00 || rpush || rx_pop) begin
			n.tmo = 11'h000;
			n.tmof = 1'b0;
		end else if (s.tick && !s.tmof) begin
			n.tmo = s.tmo + 11'h001;
			n.tmof = s.tmo + 11'h001 >= uat_lim(s.line_format_register);
		end
		if (wr && paddr == `UAT_A_ISR) begin
			if (pwdata[1] || pwdata[0] != s.fifo_setup_register[0]) begin
				n.rxw = 7'h00;
				n.rxr = 7'h00;
				n.rxc = 8'h00;
			end
			if (pwdata[2] || pwdata[0] != s.fifo_setup_register[0]) begin
				n.txw = 7'h00;
				n.txr = 7'h00;
				n.txc = 8'h00;
			end
		end
		// ----------------------------------------
		// flow control and status flag
		// ----------------------------------------
		if (!autorts) begin
			n.rts_n = ~s.modem_control_register[1];
		end else if (s.rxc >= up) begin
			n.rts_n = 1'b1;
		end else if (s.rxc <= lo) begin
			n.rts_n = 1'b0;
		end
		// clear only what the read returned; a new event still sets
		if (rd && paddr == `UAT_A_ISR) begin
			n.rcf = s.rcf & ~s.prdata[5];
		end
		if ((n.rts_n && !s.rts_n && s.interrupt_mask_register[6])
				|| (s.ct2 && !s.ctp && s.interrupt_mask_register[7])) begin
			n.rcf = 1'b1;
		end
		n.irq = pend;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.line_format_register <= `UAT_LCR_RST;
			s.div <= `UAT_DIV_RST;
			s.tx <= 1'b1;
			s.rts_n <= 1'b1;
			s.rx1 <= 1'b1;
			s.rx2 <= 1'b1;
			s.rxp <= 1'b1;
			s.ct1 <= 1'b1;
			s.ct2 <= 1'b1;
			s.ctp <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign tx = s.tx;
	assign rts_n = s.rts_n;
	assign irq = s.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic tpop_seen;
	assign tpop_seen = s.ts == uat_pkg::TX_IDLE
		&& n.ts == uat_pkg::TX_START;

	chk_tx_bitlen: assert property (
		$changed(s.tx) |-> s.tsub == 4'h0)
		else $error("tx bit edge off a bit boundary");
	chk_tx_start: assert property (
		s.ts == uat_pkg::TX_IDLE && n.ts == uat_pkg::TX_START
		|=> !tx ##1 !tx)
		else $error("start bit not low");
	chk_thr_load: assert property (
		!s.fifo_setup_register[0] && tpop_seen |=> line_state_register[5])
		else $error("holding empty not set on load");
	chk_tsr_busy: assert property (
		s.ts != uat_pkg::TX_IDLE |-> !line_state_register[6])
		else $error("transmitter empty while shifting");
	chk_cts_hold: assert property (
		s.enhanced_feature_register[7] && s.ct2 && s.ts == uat_pkg::TX_IDLE
		|=> s.ts == uat_pkg::TX_IDLE)
		else $error("character started while cts high");
	chk_rts_upper: assert property (
		autorts && s.rxc >= up |=> rts_n)
		else $error("rts not raised at upper limit");
	chk_false_st: assert property (
		s.rs == uat_pkg::RX_START && s.tick && s.rsub == 4'h7 && s.rx2
		|=> s.rs == uat_pkg::RX_IDLE && $stable(s.rxc))
		else $error("false start not dropped");
	chk_rx_accept: assert property (
		rstop && s.rxc < cap && !rx_pop |=> s.rxc == $past(s.rxc) + 8'h01)
		else $error("character lost before fifo full");
	chk_apb_ready: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one wait cycle");

	cov_tx_char: cover property (s.ts == uat_pkg::TX_STOP
		##1 s.ts == uat_pkg::TX_IDLE);
	cov_rx_push: cover property (rstop && s.rxc < cap);
	cov_rts_off: cover property (autorts && $rose(s.rts_n));
	cov_timeout: cover property ($rose(s.tmof));
endmodule : uat_top
`default_nettype wire

// ### bench/uat_remote.sv
// remote serial unit model: decodes tx, sends on rx, honours rts
`timescale 1ns/100ps
`default_nettype none
module uat_remote (
	input  wire logic pclk,
	input  wire logic tx,
	input  wire logic rts_n,
	input  wire logic hold,
	output logic      rx,
	output logic      cts_n
);
	logic [7:0] got [$];
	assign cts_n = hold;
	initial rx = 1'b1;
	// mid-bit sampling: a bit of the wrong length drifts off centre
	initial begin : rcv
		logic [7:0] b;
		forever begin
			@(negedge tx);
			repeat (8) @(posedge pclk);
			if (tx === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (16) @(posedge pclk);
					b[i] = tx;
				end
				repeat (16) @(posedge pclk);
				if (tx === 1'b1)
					got.push_back(b);
			end
		end
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		@(posedge pclk);
		// no start while the device asks us to hold off
		while (rts_n !== 1'b0)
			@(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			rx <= f[i];
			repeat (16) @(posedge pclk);
		end
	endtask : send
	task automatic glitch();
		@(posedge pclk);
		rx <= 1'b0;
		repeat (4) @(posedge pclk);
		rx <= 1'b1;
	endtask : glitch
endmodule : uat_remote
`default_nettype wire

// ### bench/tb.sv
// testbench of the serial channel: registers, line and flow control
`include "uat_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        pclk, presetn, psel, penable, pwrite, hold;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, rx, cts_n, tx, rts_n, irq, e;
	int          err_total, checks, cyc;
	typedef struct {logic [7:0] a; logic [31:0] d; logic e;} uat_row_t;
	uat_row_t    rows [8];
	uat_top uat_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx(rx), .cts_n(cts_n), .tx(tx),
		.rts_n(rts_n), .irq(irq));
	uat_remote uat_remote_i (.pclk(pclk), .tx(tx), .rts_n(rts_n),
		.hold(hold), .rx(rx), .cts_n(cts_n));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// a hang ends the run as a mismatch
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	task automatic cmp(input string n, input logic [31:0] x,
		input logic [31:0] g);
		checks++;
		if (g !== x) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, x, g);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	initial begin
		{psel, penable, pwrite, hold} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		rows = '{'{`UAT_A_LCR, 32'h03, 1'b0}, '{`UAT_A_DIV, 32'h01, 1'b0},
			'{`UAT_A_LSR, 32'h60, 1'b0}, '{`UAT_A_ISR, 32'h01, 1'b0},
			'{`UAT_A_IER, 32'h00, 1'b0}, '{`UAT_A_MCR, 32'h00, 1'b0},
			'{`UAT_A_EFR, 32'h00, 1'b0}, '{8'h20, 32'h00, 1'b1}};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// ----------------------------------------
		// reset values and the unmapped address
		// ----------------------------------------
		foreach (rows[i]) begin
			rd(rows[i].a);
			cmp("read data", rows[i].d, r);
			cmp("slave error", {31'h0, rows[i].e}, {31'h0, e});
		end
		$display("test registers done");
		// ----------------------------------------
		// awkward cases
		// ----------------------------------------
		wr(`UAT_A_MCR, 32'h02);
		wr(`UAT_A_ISR, 32'h01);
		wr(`UAT_A_DATA, 32'hA5);
		wr(`UAT_A_DATA, 32'h3C);
		rd(`UAT_A_LSR);
		cmp("busy status", 32'h0, {30'h0, r[6:5]});
		repeat (400) @(posedge pclk);
		cmp("char 0", 32'hA5, {24'h0, uat_remote_i.got[0]});
		cmp("char 1", 32'h3C, {24'h0, uat_remote_i.got[1]});
		rd(`UAT_A_LSR);
		cmp("idle status", 32'h3, {30'h0, r[6:5]});
		$display("test transmit done");
		wr(`UAT_A_IER, 32'h02);
		// irq is registered one cycle after the mask lands
		repeat (2) @(posedge pclk);
		cmp("irq on", 32'h1, {31'h0, irq});
		rd(`UAT_A_ISR);
		cmp("isr tx", 32'h2, {28'h0, r[3:0]});
		wr(`UAT_A_IER, 32'h00);
		repeat (2) @(posedge pclk);
		cmp("irq off", 32'h0, {31'h0, irq});
		$display("test interrupt done");
		uat_remote_i.send(8'h5A);
		rd(`UAT_A_LSR);
		cmp("data ready", 32'h1, {31'h0, r[0]});
		rd(`UAT_A_DATA);
		cmp("rx char", 32'h5A, {24'h0, r[7:0]});
		uat_remote_i.glitch();
		repeat (200) @(posedge pclk);
		rd(`UAT_A_LSR);
		cmp("false start", 32'h0, {31'h0, r[0]});
		$display("test receive done");
		wr(`UAT_A_IER, 32'h01);
		uat_remote_i.send(8'h77);
		rd(`UAT_A_ISR);
		cmp("below trigger", 32'h0, {30'h0, r[3:2]});
		repeat (900) @(posedge pclk);
		rd(`UAT_A_ISR);
		cmp("isr timeout", 32'h8, {28'h0, r[3:0]});
		rd(`UAT_A_DATA);
		cmp("late char", 32'h77, {24'h0, r[7:0]});
		$display("test timeout done");
		wr(`UAT_A_EFR, 32'h80);
		hold <= 1'b1;
		wr(`UAT_A_DATA, 32'hC3);
		repeat (300) @(posedge pclk);
		cmp("held count", 32'h2, uat_remote_i.got.size());
		hold <= 1'b0;
		repeat (300) @(posedge pclk);
		cmp("resumed", 32'hC3, {24'h0, uat_remote_i.got[2]});
		$display("test cts done");
		wr(`UAT_A_EFR, 32'hC0);
		wr(`UAT_A_MCR, 32'h02);
		for (int i = 0; i < 16; i++)
			uat_remote_i.send(8'(i));
		cmp("rts at upper", 32'h1, {31'h0, rts_n});
		for (int i = 0; i < 16; i++) begin
			if (i == 15)
				cmp("rts held", 32'h1, {31'h0, rts_n});
			rd(`UAT_A_DATA);
			cmp("fifo char", i, {24'h0, r[7:0]});
		end
		repeat (2) @(posedge pclk);
		cmp("rts at lower", 32'h0, {31'h0, rts_n});
		$display("test rts done");
		final_report();
	end
endmodule : tb
`default_nettype wire
